/* logic/scd_pkg.sv */
// Package of encodings and constants for the SDRAM command decode block
package scd_pkg;

  localparam int NUM_BANKS = 4;
  localparam int BANK_W    = 2;
  localparam int BURST_W   = 9;

  // Decoded command codes
  typedef enum logic [3:0] {
    SCD_CMD_NOP       = 4'h0,
    SCD_CMD_ACTIVATE  = 4'h1,
    SCD_CMD_READ      = 4'h2,
    SCD_CMD_WRITE     = 4'h3,
    SCD_CMD_PRECHARGE = 4'h4,
    SCD_CMD_MODE_SET  = 4'h5,
    SCD_CMD_BURST_END = 4'h6,
    SCD_CMD_AUTO_REF  = 4'h7,
    SCD_CMD_SELF_REF  = 4'h8
  } scd_cmd_t;

  // Power state of the device
  typedef enum logic [2:0] {
    SCD_ST_RUN        = 3'b000,
    SCD_ST_SUSP_PEND  = 3'b001,
    SCD_ST_SUSPEND    = 3'b010,
    SCD_ST_SUSP_EXIT  = 3'b011,
    SCD_ST_POWER_DOWN = 3'b100,
    SCD_ST_SELF_REF   = 3'b101
  } scd_state_t;

  // Reset values and full-page burst length
  localparam logic [NUM_BANKS-1:0] BANK_OPEN_RST  = 4'h0;
  localparam logic [BURST_W-1:0]   BURST_LEFT_RST = 9'h000;
  localparam logic [BURST_W-1:0]   FULL_PAGE_LEN  = 9'h1ff;

endpackage : scd_pkg

/* logic/scd_if.sv */
// Interface carrying command sample fields between the sampler and decoder
`timescale 1ns/1ps
interface scd_if;
  logic                         cs_n;
  logic                         ras_n;
  logic                         cas_n;
  logic                         we_n;
  logic                         ap_bit;
  logic                         mask;
  logic [scd_pkg::BANK_W-1:0]   bank;
  logic                         gate_now;
  logic                         gate_prev;

  modport producer (output cs_n, ras_n, cas_n, we_n, ap_bit, mask, bank, gate_now, gate_prev);
  modport consumer (input  cs_n, ras_n, cas_n, we_n, ap_bit, mask, bank, gate_now, gate_prev);
endinterface : scd_if

/* logic/scd_sampler.sv */
// Rising-edge sampler of command pins and clock-enable history
`timescale 1ns/1ps
module scd_sampler (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // Pins
  input  wire logic                       cs_n_pin,
  input  wire logic                       ras_n_pin,
  input  wire logic                       cas_n_pin,
  input  wire logic                       we_n_pin,
  input  wire logic                       ap_pin,
  input  wire logic                       mask_pin,
  input  wire logic [scd_pkg::BANK_W-1:0] bank_pin,
  input  wire logic                       clk_gate_pin,
  // Sampled view
  scd_if.producer                         smp
);

  logic next_gate_prev;
  logic gate_prev;

  // Pins are combinational views at the command edge; only history is held
  always_comb begin
    next_gate_prev = clk_gate_pin;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gate_prev <= 1'b1;
    end else begin
      gate_prev <= next_gate_prev;
    end
  end

  assign smp.cs_n      = cs_n_pin;
  assign smp.ras_n     = ras_n_pin;
  assign smp.cas_n     = cas_n_pin;
  assign smp.we_n      = we_n_pin;
  assign smp.ap_bit    = ap_pin;
  assign smp.mask      = mask_pin;
  assign smp.bank      = bank_pin;
  assign smp.gate_now  = clk_gate_pin;
  assign smp.gate_prev = gate_prev;

endmodule // scd_sampler

/* logic/scd_top.sv */
// SDRAM command decode with clock suspend and power down handling
// Operation
// - Commands and controls are taken only at rising clock edges.
// - Clock enable low with any bank open enters clock suspend.
// - Suspend freezes internal clock and any running burst until exit.
// - Device runs one more clock after clock enable first low.
// - New commands are ignored while suspended.
// - Clock enable high again leaves suspend one clock later.
// - Decode uses current and previous clock enable samples.
// - Auto refresh needs both samples high; self refresh now low; banks idle.
// - Read, write and activate check the selected bank's state; precharge does not.
// - Burst terminate honoured only during a full-page burst.
// - Power-down entry during a burst becomes clock suspend.
// - Read, write and activate decode from strobes; high ap bit selects auto-precharge on read and write.
// - Chip select high is no operation; no-operation never ends a burst.
`timescale 1ns/1ps
module scd_top (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // Command pins
  input  wire logic                       cs_n,
  input  wire logic                       ras_n,
  input  wire logic                       cas_n,
  input  wire logic                       we_n,
  input  wire logic                       autoprecharge_bit,
  input  wire logic                       byte_mask,
  input  wire logic [scd_pkg::BANK_W-1:0] bank_select,
  input  wire logic                       clk_gate,
  // Configuration
  input  wire logic [scd_pkg::BURST_W-1:0] burst_len,
  // Status
  output logic [3:0]                      cmd_code,
  output logic                            cmd_valid,
  output logic                            cmd_auto_pre,
  output logic [scd_pkg::BANK_W-1:0]      cmd_bank,
  output logic [scd_pkg::NUM_BANKS-1:0]   bank_open,
  output logic                            burst_active,
  output logic                            int_clk_en,
  output logic                            in_suspend,
  output logic                            in_power_down,
  output logic                            in_self_refresh,
  output logic                            data_enable
);

  scd_if smp ();

  scd_sampler u_sampler (
    .clk          (clk),
    .rst          (rst),
    .cs_n_pin     (cs_n),
    .ras_n_pin    (ras_n),
    .cas_n_pin    (cas_n),
    .we_n_pin     (we_n),
    .ap_pin       (autoprecharge_bit),
    .mask_pin     (byte_mask),
    .bank_pin     (bank_select),
    .clk_gate_pin (clk_gate),
    .smp          (smp)
  );

  // ************************************************************
  // Command decode
  // ************************************************************
  scd_pkg::scd_cmd_t raw_cmd;

  always_comb begin
    raw_cmd = scd_pkg::SCD_CMD_NOP;
    if (!smp.cs_n) begin
      case ({smp.ras_n, smp.cas_n, smp.we_n})
        3'b011:  raw_cmd = scd_pkg::SCD_CMD_ACTIVATE;
        3'b101:  raw_cmd = scd_pkg::SCD_CMD_READ;
        3'b100:  raw_cmd = scd_pkg::SCD_CMD_WRITE;
        3'b010:  raw_cmd = scd_pkg::SCD_CMD_PRECHARGE;
        3'b000:  raw_cmd = scd_pkg::SCD_CMD_MODE_SET;
        3'b110:  raw_cmd = scd_pkg::SCD_CMD_BURST_END;
        3'b001:  raw_cmd = smp.gate_now ? scd_pkg::SCD_CMD_AUTO_REF
                                        : scd_pkg::SCD_CMD_SELF_REF;
        default: raw_cmd = scd_pkg::SCD_CMD_NOP;
      endcase
    end
  end

  // ************************************************************
  // Power state and bank tracking
  // ************************************************************
  scd_pkg::scd_state_t               state;
  scd_pkg::scd_state_t               next_state;
  logic [scd_pkg::NUM_BANKS-1:0]     next_bank_open;
  logic [scd_pkg::BURST_W-1:0]       burst_left;
  logic [scd_pkg::BURST_W-1:0]       next_burst_left;
  logic                              full_page;
  logic                              next_full_page;
  logic [3:0]                        next_cmd_code;
  logic                              next_cmd_valid;
  logic                              next_cmd_auto_pre;
  logic [scd_pkg::BANK_W-1:0]        next_cmd_bank;
  logic                              next_data_enable;
  logic                              running;
  logic                              sel_open;
  logic                              any_open;
  logic                              all_idle;
  logic                              accept;

  // Commands count only while the internal clock runs
  assign running  = (state == scd_pkg::SCD_ST_RUN) || (state == scd_pkg::SCD_ST_SUSP_PEND);
  assign sel_open = bank_open[smp.bank];
  assign any_open = |bank_open;
  assign all_idle = ~any_open;
  // Commands need the previous sample high
  assign accept   = running && smp.gate_prev && (state == scd_pkg::SCD_ST_RUN);

  always_comb begin
    next_state        = state;
    next_bank_open    = bank_open;
    next_burst_left   = burst_left;
    next_full_page    = full_page;
    next_cmd_code     = scd_pkg::SCD_CMD_NOP;
    next_cmd_valid    = 1'b0;
    next_cmd_auto_pre = 1'b0;
    next_cmd_bank     = smp.bank;
    // Burst advances only while the internal clock runs
    if (running && burst_left != scd_pkg::BURST_LEFT_RST && !full_page) begin
      next_burst_left = burst_left - 9'h001;
    end
    if (accept) begin
      case (raw_cmd)
        scd_pkg::SCD_CMD_ACTIVATE: begin
          if (!sel_open) begin
            next_bank_open[smp.bank] = 1'b1;
            next_cmd_valid = 1'b1;
          end
        end
        scd_pkg::SCD_CMD_READ,
        scd_pkg::SCD_CMD_WRITE: begin
          if (sel_open) begin
            next_cmd_valid    = 1'b1;
            next_cmd_auto_pre = smp.ap_bit;
            next_full_page    = (burst_len == scd_pkg::FULL_PAGE_LEN);
            next_burst_left   = burst_len;
          end
        end
        scd_pkg::SCD_CMD_PRECHARGE: begin
          next_cmd_valid    = 1'b1;
          next_cmd_auto_pre = smp.ap_bit;
          if (smp.ap_bit) begin
            next_bank_open = scd_pkg::BANK_OPEN_RST;
          end else begin
            next_bank_open[smp.bank] = 1'b0;
          end
          next_burst_left = scd_pkg::BURST_LEFT_RST;
          next_full_page  = 1'b0;
        end
        scd_pkg::SCD_CMD_BURST_END: begin
          if (full_page && burst_left != scd_pkg::BURST_LEFT_RST) begin
            next_cmd_valid  = 1'b1;
            next_burst_left = scd_pkg::BURST_LEFT_RST;
            next_full_page  = 1'b0;
          end
        end
        scd_pkg::SCD_CMD_MODE_SET: begin
          next_cmd_valid = all_idle;
        end
        scd_pkg::SCD_CMD_AUTO_REF: begin
          next_cmd_valid = all_idle && smp.gate_now && smp.gate_prev;
        end
        scd_pkg::SCD_CMD_SELF_REF: begin
          next_cmd_valid = all_idle;
        end
        default: ; // No operation leaves bursts running
      endcase
      if (next_cmd_valid) begin
        next_cmd_code = raw_cmd;
      end
    end

    case (state)
      scd_pkg::SCD_ST_RUN: begin
        if (smp.gate_prev && !smp.gate_now) begin
          if (raw_cmd == scd_pkg::SCD_CMD_SELF_REF && all_idle) begin
            next_state = scd_pkg::SCD_ST_SELF_REF;
          end else if (any_open || burst_left != scd_pkg::BURST_LEFT_RST) begin
            // Burst or open bank forces suspend, never power down
            next_state = scd_pkg::SCD_ST_SUSP_PEND;
          end else begin
            next_state = scd_pkg::SCD_ST_POWER_DOWN;
          end
        end
      end
      scd_pkg::SCD_ST_SUSP_PEND: begin
        // One more running clock, then freeze
        next_state = smp.gate_now ? scd_pkg::SCD_ST_RUN : scd_pkg::SCD_ST_SUSPEND;
      end
      scd_pkg::SCD_ST_SUSPEND: begin
        if (!smp.gate_prev && smp.gate_now) begin
          next_state = scd_pkg::SCD_ST_SUSP_EXIT;
        end
      end
      scd_pkg::SCD_ST_SUSP_EXIT: begin
        next_state = smp.gate_now ? scd_pkg::SCD_ST_RUN : scd_pkg::SCD_ST_SUSPEND;
      end
      scd_pkg::SCD_ST_POWER_DOWN,
      scd_pkg::SCD_ST_SELF_REF: begin
        // Exit needs a rising clock enable; the edge that sees it takes no command, the next edge does
        if (!smp.gate_prev && smp.gate_now) begin
          next_state = scd_pkg::SCD_ST_RUN;
        end
      end
      default: next_state = scd_pkg::SCD_ST_RUN;
    endcase

    // Mask only matters with an active bank
    next_data_enable = any_open && !smp.mask && running;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state        <= scd_pkg::SCD_ST_RUN;
      bank_open    <= scd_pkg::BANK_OPEN_RST;
      burst_left   <= scd_pkg::BURST_LEFT_RST;
      full_page    <= 1'b0;
      cmd_code     <= 4'h0;
      cmd_valid    <= 1'b0;
      cmd_auto_pre <= 1'b0;
      cmd_bank     <= 2'h0;
      data_enable  <= 1'b0;
    end else begin
      state        <= next_state;
      bank_open    <= next_bank_open;
      burst_left   <= next_burst_left;
      full_page    <= next_full_page;
      cmd_code     <= next_cmd_code;
      cmd_valid    <= next_cmd_valid;
      cmd_auto_pre <= next_cmd_auto_pre;
      cmd_bank     <= next_cmd_bank;
      data_enable  <= next_data_enable;
    end
  end

  assign burst_active    = (burst_left != scd_pkg::BURST_LEFT_RST);
  assign int_clk_en      = running || (state == scd_pkg::SCD_ST_SUSP_EXIT);
  assign in_suspend      = (state == scd_pkg::SCD_ST_SUSPEND);
  assign in_power_down   = (state == scd_pkg::SCD_ST_POWER_DOWN);
  assign in_self_refresh = (state == scd_pkg::SCD_ST_SELF_REF);

endmodule // scd_top

/* sim/scd_checker.sv */
// Assertion checker on the ports of the SDRAM command decode block
`timescale 1ns/1ps
module scd_checker (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Command pins and burst length
  input wire logic       cs_n,
  input wire logic       ras_n,
  input wire logic       cas_n,
  input wire logic       we_n,
  input wire logic       autoprecharge_bit,
  input wire logic       byte_mask,
  input wire logic [1:0] bank_select,
  input wire logic       clk_gate,
  input wire logic [8:0] burst_len,
  // Status
  input wire logic [3:0] cmd_code,
  input wire logic       cmd_valid,
  input wire logic       cmd_auto_pre,
  input wire logic [1:0] cmd_bank,
  input wire logic [3:0] bank_open,
  input wire logic       burst_active,
  input wire logic       int_clk_en,
  input wire logic       in_suspend,
  input wire logic       in_power_down,
  input wire logic       in_self_refresh,
  input wire logic       data_enable
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_desel; $past(cs_n) |-> !cmd_valid; endproperty
  a_desel: assert property (p_desel) else $error("command taken while deselected");
  property p_rw;
    cmd_valid && cmd_code inside {4'h2, 4'h3} |-> $past(ras_n) && !$past(cas_n)
      && ($past(we_n) == (cmd_code == 4'h2)) && cmd_auto_pre == $past(autoprecharge_bit);
  endproperty
  a_rw: assert property (p_rw) else $error("read or write decode wrong");
  property p_ign; in_suspend |=> !cmd_valid; endproperty
  a_ign: assert property (p_ign) else $error("command taken in suspend");
  property p_late; $fell(clk_gate) && |bank_open |=> int_clk_en && !in_suspend; endproperty
  a_late: assert property (p_late) else $error("suspend came too early");
  property p_susp;
    $fell(clk_gate) && |bank_open ##1 !clk_gate |=> in_suspend && !in_power_down;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend not entered");
  property p_exit; in_suspend && clk_gate |=> int_clk_en ##1 !in_suspend; endproperty
  a_exit: assert property (p_exit) else $error("suspend exit late");
  property p_ref;
    cmd_valid && cmd_code == 4'h7 |-> $past(clk_gate) && $past(clk_gate, 2)
      && $past(bank_open) == 4'h0;
  endproperty
  a_ref: assert property (p_ref) else $error("auto refresh wrongly taken");
  property p_act;
    cmd_valid && cmd_code == 4'h1 |-> !$past(bank_open[bank_select])
      && cmd_bank == $past(bank_select);
  endproperty
  a_act: assert property (p_act) else $error("activate to open bank");
  property p_bst;
    cmd_valid && cmd_code == 4'h6 |-> $past(burst_active) && $past(burst_len) == 9'h1ff;
  endproperty
  a_bst: assert property (p_bst) else $error("burst end outside full page");
  property p_mask; $past(byte_mask) |-> !data_enable; endproperty
  a_mask: assert property (p_mask) else $error("data enabled while masked");
endmodule // scd_checker
bind scd_top scd_checker u_chk (.clk(clk), .rst(rst), .cs_n(cs_n), .ras_n(ras_n),
  .cas_n(cas_n), .we_n(we_n), .autoprecharge_bit(autoprecharge_bit), .byte_mask(byte_mask),
  .bank_select(bank_select), .clk_gate(clk_gate), .burst_len(burst_len), .cmd_code(cmd_code),
  .cmd_valid(cmd_valid), .cmd_auto_pre(cmd_auto_pre), .cmd_bank(cmd_bank),
  .bank_open(bank_open), .burst_active(burst_active), .int_clk_en(int_clk_en),
  .in_suspend(in_suspend), .in_power_down(in_power_down),
  .in_self_refresh(in_self_refresh), .data_enable(data_enable));

/* sim/scd_ctl_model.sv */
// Memory controller model driving the command pins
`timescale 1ns/1ps
module scd_ctl_model (
  // Clock
  input wire logic  clk,
  // Pins: {cs_n, ras_n, cas_n, we_n}
  output logic [3:0] pins,
  output logic       ap,
  output logic [1:0] bank,
  output logic       gate,
  output logic       mask
);
  // ****
  // Drive tasks
  // ****
  // Held a full cycle, so the rising edge sees a settled command
  task automatic send(input logic [3:0] p, input logic a, input logic [1:0] b);
    @(negedge clk);
    pins = p;
    ap = a;
    bank = b;
  endtask
  // Raising the gate always comes with a no-operation
  task automatic wake();
    @(negedge clk);
    gate = 1'h1;
    pins = 4'h7;
  endtask
  initial begin
    pins = 4'h7;
    ap = 1'h0;
    bank = 2'h0;
    gate = 1'h1;
    mask = 1'h0;
  end
endmodule // scd_ctl_model

/* sim/tb.sv */
// Self-checking testbench for the SDRAM command decode block
`timescale 1ns/1ps
module tb;
  logic       clk, rst, ap, mask, gate, cmd_valid, cmd_auto_pre, burst_active;
  logic       int_clk_en, in_suspend, in_power_down, in_self_refresh, data_enable;
  logic [8:0] burst_len;
  logic [3:0] pins, cmd_code, bank_open;
  logic [1:0] bank, cmd_bank;
  int         n_fail, checks_done;
  scd_ctl_model ctl (.clk(clk), .pins(pins), .ap(ap), .bank(bank), .gate(gate), .mask(mask));
  scd_top DUT (.clk(clk), .rst(rst), .cs_n(pins[3]), .ras_n(pins[2]), .cas_n(pins[1]),
    .we_n(pins[0]), .autoprecharge_bit(ap), .byte_mask(mask), .bank_select(bank),
    .clk_gate(gate), .burst_len(burst_len), .cmd_code(cmd_code), .cmd_valid(cmd_valid),
    .cmd_auto_pre(cmd_auto_pre), .cmd_bank(cmd_bank), .bank_open(bank_open),
    .burst_active(burst_active), .int_clk_en(int_clk_en), .in_suspend(in_suspend),
    .in_power_down(in_power_down), .in_self_refresh(in_self_refresh),
    .data_enable(data_enable));
  // ****
  // Helpers
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One command then a no-operation; answer is looked at one edge later
  task automatic op(input logic [3:0] p, input logic a, input logic [1:0] b, input logic [7:0] e);
    ctl.send(p, a, b);
    ctl.send(4'h7, 1'h0, b);
    chk(cmd_valid ? {2'h0, cmd_auto_pre, 1'h1, cmd_code} : 8'h00, e);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Tests take about 50 cycles; the limit allows ten times that
  initial begin
    #5000;
    n_fail++;
    tally_and_finish();
  end
  // ****
  // Tests
  // ****
  initial begin
    rst = 1'h1;
    burst_len = 9'h1ff;
    n_fail = 0;
    checks_done = 0;
    repeat (2) @(negedge clk);
    rst = 1'h0;
    chk(8'({bank_open, int_clk_en, in_suspend}), 8'h02);
    op(4'h3, 1'h0, 2'h2, 8'h11);
    chk(8'({cmd_bank, bank_open}), 8'h24);
    op(4'h3, 1'h0, 2'h2, 8'h00);
    op(4'h5, 1'h0, 2'h1, 8'h00);
    op(4'h1, 1'h0, 2'h0, 8'h00);
    op(4'h6, 1'h0, 2'h2, 8'h00);
    op(4'h5, 1'h0, 2'h2, 8'h12);
    chk(8'({burst_active, data_enable}), 8'h03);
    ctl.mask = 1'h1;
    @(negedge clk);
    chk(8'(data_enable), 8'h00);
    ctl.mask = 1'h0;
    $display("test decode done");
    // Power-down pattern during a burst must become suspend
    ctl.send(4'h8, 1'h0, 2'h0);
    ctl.gate = 1'h0;
    @(negedge clk);
    chk(8'({int_clk_en, in_suspend}), 8'h02);
    ctl.pins = 4'h3;
    @(negedge clk);
    chk(8'({in_suspend, in_power_down, int_clk_en}), 8'h04);
    repeat (2) @(negedge clk);
    chk(8'({cmd_valid, burst_active, bank_open}), 8'h14);
    ctl.wake();
    @(negedge clk);
    chk(8'(int_clk_en), 8'h01);
    @(negedge clk);
    chk(8'({in_suspend, burst_active}), 8'h01);
    $display("test suspend done");
    op(4'h8, 1'h0, 2'h2, 8'h00);
    op(4'h6, 1'h0, 2'h2, 8'h16);
    chk(8'(burst_active), 8'h00);
    burst_len = 9'h004;
    op(4'h4, 1'h1, 2'h2, 8'h33);
    // Short burst: a counter that kept running would be empty by now
    ctl.gate = 1'h0;
    repeat (4) @(negedge clk);
    chk(8'({in_suspend, burst_active}), 8'h03);
    ctl.wake();
    repeat (2) @(negedge clk);
    chk(8'({in_suspend, int_clk_en, burst_active}), 8'h03);
    op(4'h2, 1'h1, 2'h0, 8'h34);
    chk(8'(bank_open), 8'h00);
    op(4'h1, 1'h0, 2'h0, 8'h17);
    op(4'h0, 1'h0, 2'h0, 8'h15);
    $display("test refresh done");
    ctl.send(4'h8, 1'h0, 2'h0);
    ctl.gate = 1'h0;
    repeat (2) @(negedge clk);
    chk(8'({in_power_down, in_suspend}), 8'h02);
    ctl.wake();
    repeat (2) @(negedge clk);
    chk(8'(in_power_down), 8'h00);
    ctl.send(4'h1, 1'h0, 2'h0);
    ctl.gate = 1'h0;
    @(negedge clk);
    chk(8'({in_self_refresh, cmd_valid, cmd_code}), 8'h38);
    $display("test power states done");
    tally_and_finish();
  end
endmodule // tb
